//--- rtl/ducp_chan.sv
// One serial channel: transmitter with holding register and receiver with FIFO
`default_nettype none
module ducp_chan
  import ducp_pkg::*;
#(
  parameter int DEPTH = RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  reset_n,
  // Hub side
  ducp_chan_if.chan  c
);
  localparam int PW = $clog2(DEPTH);

  // ***********************************************
  // State
  // ***********************************************
  ducp_tx_st_t          tx_st_ff, nxt_tx_st;
  ducp_rx_st_t          rx_st_ff, nxt_rx_st;
  logic [DATA_BITS-1:0] hold_ff, nxt_hold, tsh_ff, nxt_tsh, rsh_ff, nxt_rsh;
  logic                 hfull_ff, nxt_hfull, line_ff, nxt_line, ovr_ff, nxt_ovr;
  logic [2:0]           tcnt_ff, nxt_tcnt, rcnt_ff, nxt_rcnt;
  logic [DATA_BITS-1:0] mem_ff [DEPTH];
  logic [DATA_BITS-1:0] nxt_mem [DEPTH];
  logic [PW-1:0]        wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [PW:0]          cnt_ff, nxt_cnt;
  logic                 rx_bit, push, pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_rx_st = rx_st_ff;
    nxt_hold  = hold_ff;
    nxt_hfull = hfull_ff;
    nxt_tsh   = tsh_ff;
    nxt_tcnt  = tcnt_ff;
    nxt_line  = line_ff;
    nxt_rsh   = rsh_ff;
    nxt_rcnt  = rcnt_ff;
    nxt_mem   = mem_ff;
    nxt_wp    = wp_ff;
    nxt_rp    = rp_ff;
    nxt_cnt   = cnt_ff;
    nxt_ovr   = ovr_ff;
    push      = 1'b0;
    // Loopback feeds the receiver from the transmitter internally
    rx_bit    = c.loopback ? line_ff : c.rx_in;
    if (c.tx_load && !hfull_ff) begin
      nxt_hold  = c.tx_data;
      nxt_hfull = 1'b1;
    end
    if (!c.tx_enable) begin
      nxt_tx_st = TX_IDLE;
      nxt_line  = 1'b1;
    end else if (c.bit_fall) begin
      unique case (tx_st_ff)
        TX_IDLE: begin
          // A new character waits for clear-to-send; one in flight finishes
          if (hfull_ff && c.cts_gate) begin
            nxt_tsh   = hold_ff;
            nxt_hfull = 1'b0;
            nxt_line  = 1'b0;
            nxt_tcnt  = '0;
            nxt_tx_st = TX_DATA;
          end
        end
        TX_DATA: begin
          nxt_line = tsh_ff[0];
          nxt_tsh  = tsh_ff >> 1;
          nxt_tcnt = tcnt_ff + 3'h1;
          if (tcnt_ff == BIT_CNT_LAST) begin
            nxt_tx_st = TX_STOP;
          end
        end
        TX_STOP: begin
          nxt_line  = 1'b1;
          nxt_tx_st = TX_IDLE;
        end
      endcase
    end
    if (c.bit_rise) begin
      unique case (rx_st_ff)
        RX_IDLE: begin
          if (!rx_bit) begin
            nxt_rcnt  = '0;
            nxt_rx_st = RX_DATA;
          end
        end
        RX_DATA: begin
          nxt_rsh  = {rx_bit, rsh_ff[DATA_BITS-1:1]};
          nxt_rcnt = rcnt_ff + 3'h1;
          if (rcnt_ff == BIT_CNT_LAST) begin
            nxt_rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          push      = rx_bit;
          nxt_rx_st = RX_IDLE;
        end
      endcase
    end
    pop = c.rx_pop && (cnt_ff != '0);
    if (pop) begin
      nxt_rp = ptr_inc(rp_ff);
    end
    if (push && (!(cnt_ff == (PW+1)'(DEPTH)) || pop)) begin
      nxt_mem[wp_ff] = rsh_ff;
      nxt_wp         = ptr_inc(wp_ff);
    end
    nxt_cnt = cnt_ff + (PW+1)'(push && (!(cnt_ff == (PW+1)'(DEPTH)) || pop)) - (PW+1)'(pop);
    // Overrun set wins over a clear in the same cycle
    if (c.ovr_clr) begin
      nxt_ovr = 1'b0;
    end
    if (push && (cnt_ff == (PW+1)'(DEPTH)) && !pop) begin
      nxt_ovr = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_ff <= TX_IDLE;
      rx_st_ff <= RX_IDLE;
      hold_ff  <= '0;
      hfull_ff <= 1'b0;
      tsh_ff   <= '0;
      tcnt_ff  <= '0;
      line_ff  <= 1'b1;
      rsh_ff   <= '0;
      rcnt_ff  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      wp_ff    <= '0;
      rp_ff    <= '0;
      cnt_ff   <= '0;
      ovr_ff   <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      rx_st_ff <= nxt_rx_st;
      hold_ff  <= nxt_hold;
      hfull_ff <= nxt_hfull;
      tsh_ff   <= nxt_tsh;
      tcnt_ff  <= nxt_tcnt;
      line_ff  <= nxt_line;
      rsh_ff   <= nxt_rsh;
      rcnt_ff  <= nxt_rcnt;
      mem_ff   <= nxt_mem;
      wp_ff    <= nxt_wp;
      rp_ff    <= nxt_rp;
      cnt_ff   <= nxt_cnt;
      ovr_ff   <= nxt_ovr;
    end
  end

  // ***********************************************
  // Outputs to hub
  // ***********************************************
  assign c.tx_out = (c.loopback || !c.tx_enable || tx_st_ff == TX_IDLE) ? 1'b1 : line_ff;
  assign c.rx_data = mem_ff[rp_ff];
  assign c.status  = {ovr_ff, !hfull_ff && tx_st_ff == TX_IDLE, !hfull_ff,
                      cnt_ff == (PW+1)'(DEPTH), cnt_ff != '0};
endmodule : ducp_chan
`default_nettype wire

//--- rtl/ducp_chan_if.sv
// Signals between the pin hub and one serial channel
`default_nettype none
interface ducp_chan_if;
  import ducp_pkg::*;
  logic                 bit_rise;
  logic                 bit_fall;
  logic                 tx_enable;
  logic                 loopback;
  logic                 cts_gate;
  logic                 tx_load;
  logic [DATA_BITS-1:0] tx_data;
  logic                 rx_in;
  logic                 rx_pop;
  logic                 ovr_clr;
  logic                 tx_out;
  logic [DATA_BITS-1:0] rx_data;
  logic [SR_WIDTH-1:0]  status;
  modport hub (output bit_rise, bit_fall, tx_enable, loopback, cts_gate, tx_load, tx_data,
               rx_in, rx_pop, ovr_clr, input tx_out, rx_data, status);
  modport chan (input bit_rise, bit_fall, tx_enable, loopback, cts_gate, tx_load, tx_data,
                rx_in, rx_pop, ovr_clr, output tx_out, rx_data, status);
endinterface : ducp_chan_if
`default_nettype wire

//--- rtl/ducp_pkg.sv
// Constants and types shared by the dual serial pin block
`default_nettype none
package ducp_pkg;
  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int SR_RXRDY      = 0;
  localparam int SR_FFULL      = 1;
  localparam int SR_TXRDY      = 2;
  localparam int SR_TXEMT      = 3;
  localparam int SR_OVRUN      = 4;
  localparam int SR_WIDTH      = 5;
  localparam int ISR_RX_BIT    = 1;
  localparam int OP_RTS_A_BIT  = 0;
  localparam int OP_RTS_B_BIT  = 1;
  localparam int OP_RXRDY_BIT  = 4;
  localparam int OP_TXRDY_BIT  = 6;
  // ***********************************************
  // Sizes and reset values
  // ***********************************************
  localparam int DATA_BITS     = 8;
  localparam int RX_FIFO_DEPTH = 3;
  localparam int NUM_SYNC      = 6;
  localparam int BAUD_W        = 16;
  localparam logic [BAUD_W-1:0] BAUD_DIV_RST = 16'h0001;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [NUM_SYNC-1:0] SYNC_RST = 6'h3c; // Idle pin levels: no false edge after reset
  // Sync vector slots
  localparam int SY_OSC = 0;
  localparam int SY_EXT = 1;
  localparam int SY_RXA = 2;
  localparam int SY_RXB = 3;
  localparam int SY_CTA = 4;
  localparam int SY_CTB = 5;
  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [1:0] {RDY_RXRDY, RDY_FFULL, RDY_DISCRETE} ducp_rdy_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP} ducp_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} ducp_rx_st_t;
endpackage : ducp_pkg
`default_nettype wire

//--- rtl/ducp_top.sv
// Pin level logic of a two channel asynchronous serial module
// ***********************************************
// Overview of operation
// - Receiver samples rising edge, LSB first
// - Serial output marks when disabled, idle, loopback
// - Transmitter shifts on falling edge, LSB first
// - External serial clock selectable per channel
// - Active-low clear-to-send input per channel
// - Request-to-send pins or discrete bits 1, 0
// - Transmit ready pin is inverse status bit 2
// - Receive ready pin is inverse interrupt bit 1
// - FIFO full pin is inverse interrupt bit 1
// - Transmit ready discrete follows output bit 6
// - Receive ready discrete follows output bit 4
// ***********************************************
`default_nettype none
module ducp_top
  import ducp_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Serial pins
  input  wire logic                 serial_in_chan_a,
  input  wire logic                 serial_in_chan_b,
  output logic                      serial_out_chan_a,
  output logic                      serial_out_chan_b,
  input  wire logic                 clear_to_send_chan_a_n,
  input  wire logic                 clear_to_send_chan_b_n,
  input  wire logic                 serial_osc_in,
  input  wire logic                 serial_clk_ext,
  // Multiplexed handshake pins, active low
  output logic                      request_to_send_chan_a_n,
  output logic                      request_to_send_chan_b_n,
  output logic                      transmit_ready_chan_a_n,
  output logic                      receive_ready_chan_a_n,
  // Configuration, index 0 is channel A
  input  wire logic [1:0]           tx_enable,
  input  wire logic [1:0]           loopback,
  input  wire logic [1:0]           cts_enable,
  input  wire logic [1:0]           ext_clk_sel,
  input  wire logic [BAUD_W-1:0]    baud_div,
  input  wire logic [1:0]           rts_func_sel,
  input  wire logic [1:0]           rts_request,
  input  wire logic                 txrdy_func_sel,
  input  wire ducp_rdy_mode_t       rxrdy_mode,
  input  wire logic [7:0]           out_port_data,
  // Data path
  input  wire logic [1:0]           tx_write,
  input  wire logic [DATA_BITS-1:0] tx_data_chan_a,
  input  wire logic [DATA_BITS-1:0] tx_data_chan_b,
  input  wire logic [1:0]           rx_read,
  input  wire logic [1:0]           overrun_clr,
  // Status
  output logic [DATA_BITS-1:0]      rx_data_chan_a,
  output logic [DATA_BITS-1:0]      rx_data_chan_b,
  output logic [SR_WIDTH-1:0]       status_chan_a,
  output logic [SR_WIDTH-1:0]       status_chan_b,
  output logic [7:0]                int_status
);

  // ***********************************************
  // Declarations
  // ***********************************************
  ducp_chan_if ch_a ();
  ducp_chan_if ch_b ();

  logic [NUM_SYNC-1:0]  meta_ff, sync_ff;
  logic                 osc_last_ff, nxt_osc_last;
  logic [BAUD_W-1:0]    baud_cnt_ff, nxt_baud_cnt;
  logic                 baud_clk_ff, nxt_baud_clk;
  logic [1:0]           bclk_last_ff, nxt_bclk_last;
  logic [1:0]           bclk_sel;
  logic                 isr_rx;
  logic [1:0]           nxt_sout, sout_ff;
  logic [1:0]           nxt_rts, rts_ff;
  logic                 nxt_txrdy, txrdy_ff, nxt_rxrdy, rxrdy_ff;
  logic [DATA_BITS-1:0] nxt_rxd_a, rxd_a_ff, nxt_rxd_b, rxd_b_ff;
  logic [SR_WIDTH-1:0]  nxt_sr_a, sr_a_ff, nxt_sr_b, sr_b_ff;
  logic [7:0]           nxt_isr, isr_ff;

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  // Pins are asynchronous to core_clk; first stage feeds only the second
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= {clear_to_send_chan_b_n, clear_to_send_chan_a_n, serial_in_chan_b,
                  serial_in_chan_a, serial_clk_ext, serial_osc_in};
      sync_ff <= meta_ff;
    end
  end

  // ***********************************************
  // Bit clock generation
  // ***********************************************
  // The oscillator is sampled, so it must stay well below half of core_clk
  always_comb begin
    nxt_osc_last = sync_ff[SY_OSC];
    nxt_baud_cnt = baud_cnt_ff;
    nxt_baud_clk = baud_clk_ff;
    if (sync_ff[SY_OSC] && !osc_last_ff) begin
      if (baud_cnt_ff >= baud_div - 16'h0001 || baud_div == '0) begin
        nxt_baud_cnt = '0;
        nxt_baud_clk = !baud_clk_ff;
      end else begin
        nxt_baud_cnt = baud_cnt_ff + 16'h0001;
      end
    end
    for (int i = 0; i < 2; i++) begin
      // External clock bypasses the baud divider entirely
      bclk_sel[i] = ext_clk_sel[i] ? sync_ff[SY_EXT] : baud_clk_ff;
    end
    nxt_bclk_last = bclk_sel;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_last_ff  <= 1'b0;
      baud_cnt_ff  <= '0;
      baud_clk_ff  <= 1'b0;
      bclk_last_ff <= '0;
    end else begin
      osc_last_ff  <= nxt_osc_last;
      baud_cnt_ff  <= nxt_baud_cnt;
      baud_clk_ff  <= nxt_baud_clk;
      bclk_last_ff <= nxt_bclk_last;
    end
  end

  // ***********************************************
  // Channel hookup
  // ***********************************************
  assign ch_a.bit_rise  = bclk_sel[0] && !bclk_last_ff[0];
  assign ch_a.bit_fall  = !bclk_sel[0] && bclk_last_ff[0];
  assign ch_a.tx_enable = tx_enable[0];
  assign ch_a.loopback  = loopback[0];
  assign ch_a.cts_gate  = !cts_enable[0] || !sync_ff[SY_CTA];
  assign ch_a.tx_load   = tx_write[0];
  assign ch_a.tx_data   = tx_data_chan_a;
  assign ch_a.rx_in     = sync_ff[SY_RXA];
  assign ch_a.rx_pop    = rx_read[0];
  assign ch_a.ovr_clr   = overrun_clr[0];

  assign ch_b.bit_rise  = bclk_sel[1] && !bclk_last_ff[1];
  assign ch_b.bit_fall  = !bclk_sel[1] && bclk_last_ff[1];
  assign ch_b.tx_enable = tx_enable[1];
  assign ch_b.loopback  = loopback[1];
  assign ch_b.cts_gate  = !cts_enable[1] || !sync_ff[SY_CTB];
  assign ch_b.tx_load   = tx_write[1];
  assign ch_b.tx_data   = tx_data_chan_b;
  assign ch_b.rx_in     = sync_ff[SY_RXB];
  assign ch_b.rx_pop    = rx_read[1];
  assign ch_b.ovr_clr   = overrun_clr[1];

  ducp_chan #(
    .DEPTH (FIFO_DEPTH)
  ) u_chan_a (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .c        (ch_a.chan)
  );

  ducp_chan #(
    .DEPTH (FIFO_DEPTH)
  ) u_chan_b (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .c        (ch_b.chan)
  );

  // ***********************************************
  // Pin multiplexing and output registers
  // ***********************************************
  always_comb begin
    // Interrupt status bit 1 reports a character or a full FIFO per mode
    isr_rx = (rxrdy_mode == RDY_FFULL) ? ch_a.status[SR_FFULL]
                                       : ch_a.status[SR_RXRDY];
    nxt_isr = '0;
    nxt_isr[ISR_RX_BIT] = isr_rx;
    nxt_sout  = {ch_b.tx_out, ch_a.tx_out};
    nxt_rts[0] = rts_func_sel[0] ? !rts_request[0] : out_port_data[OP_RTS_A_BIT];
    nxt_rts[1] = rts_func_sel[1] ? !rts_request[1] : out_port_data[OP_RTS_B_BIT];
    if (txrdy_func_sel) begin
      nxt_txrdy = !ch_a.status[SR_TXRDY];
    end else begin
      nxt_txrdy = out_port_data[OP_TXRDY_BIT];
    end
    unique case (rxrdy_mode)
      RDY_RXRDY: nxt_rxrdy = !isr_rx;
      RDY_FFULL: nxt_rxrdy = !isr_rx;
      default:   nxt_rxrdy = out_port_data[OP_RXRDY_BIT];
    endcase
    nxt_rxd_a = ch_a.rx_data;
    nxt_rxd_b = ch_b.rx_data;
    nxt_sr_a  = ch_a.status;
    nxt_sr_b  = ch_b.status;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sout_ff  <= 2'h3;
      rts_ff   <= 2'h3;
      txrdy_ff <= 1'b1;
      rxrdy_ff <= 1'b1;
      rxd_a_ff <= '0;
      rxd_b_ff <= '0;
      sr_a_ff  <= '0;
      sr_b_ff  <= '0;
      isr_ff   <= '0;
    end else begin
      sout_ff  <= nxt_sout;
      rts_ff   <= nxt_rts;
      txrdy_ff <= nxt_txrdy;
      rxrdy_ff <= nxt_rxrdy;
      rxd_a_ff <= nxt_rxd_a;
      rxd_b_ff <= nxt_rxd_b;
      sr_a_ff  <= nxt_sr_a;
      sr_b_ff  <= nxt_sr_b;
      isr_ff   <= nxt_isr;
    end
  end

  assign serial_out_chan_a        = sout_ff[0];
  assign serial_out_chan_b        = sout_ff[1];
  assign request_to_send_chan_a_n = rts_ff[0];
  assign request_to_send_chan_b_n = rts_ff[1];
  assign transmit_ready_chan_a_n  = txrdy_ff;
  assign receive_ready_chan_a_n   = rxrdy_ff;
  assign rx_data_chan_a           = rxd_a_ff;
  assign rx_data_chan_b           = rxd_b_ff;
  assign status_chan_a            = sr_a_ff;
  assign status_chan_b            = sr_b_ff;
  assign int_status               = isr_ff;
endmodule : ducp_top
`default_nettype wire

//--- sim/ducp_checker.sv
// Pin assertions for the dual serial block
`default_nettype none
module ducp_checker
  import ducp_pkg::*;
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                reset_n,
  // Pins
  input wire logic                serial_out_chan_a,
  input wire logic                serial_out_chan_b,
  input wire logic                serial_clk_ext,
  input wire logic                request_to_send_chan_a_n,
  input wire logic                request_to_send_chan_b_n,
  input wire logic                transmit_ready_chan_a_n,
  input wire logic                receive_ready_chan_a_n,
  // Configuration and status
  input wire logic [1:0]          tx_enable,
  input wire logic [1:0]          loopback,
  input wire logic [1:0]          ext_clk_sel,
  input wire logic [1:0]          rts_func_sel,
  input wire logic [1:0]          rts_request,
  input wire logic                txrdy_func_sel,
  input wire ducp_rdy_mode_t      rxrdy_mode,
  input wire logic [7:0]          out_port_data,
  input wire logic [SR_WIDTH-1:0] status_chan_a,
  input wire logic [7:0]          int_status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Age of the last external clock fall; saturates so a stopped clock never wraps
  logic [3:0] fall_age_ff;
  logic [3:0] nxt_fall_age;
  logic       clk_ext_ff;
  always_comb begin
    nxt_fall_age = (fall_age_ff == 4'hf) ? fall_age_ff : fall_age_ff + 4'h1;
    if (clk_ext_ff && !serial_clk_ext) nxt_fall_age = 4'h0;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fall_age_ff <= 4'hf;
      clk_ext_ff  <= 1'b0;
    end else begin
      fall_age_ff <= nxt_fall_age;
      clk_ext_ff  <= serial_clk_ext;
    end
  end
  property p_rts_a;
    $past(reset_n) |-> request_to_send_chan_a_n == ($past(rts_func_sel[0]) ?
      !$past(rts_request[0]) : $past(out_port_data[OP_RTS_A_BIT]));
  endproperty
  a_rts_a: assert property (p_rts_a) else $error("rts a pin wrong");
  property p_rts_b;
    $past(reset_n) |-> request_to_send_chan_b_n == ($past(rts_func_sel[1]) ?
      !$past(rts_request[1]) : $past(out_port_data[OP_RTS_B_BIT]));
  endproperty
  a_rts_b: assert property (p_rts_b) else $error("rts b pin wrong");
  property p_txrdy;
    (txrdy_func_sel && $stable(status_chan_a[SR_TXRDY]))[*3]
      |-> transmit_ready_chan_a_n == !status_chan_a[SR_TXRDY];
  endproperty
  a_txrdy: assert property (p_txrdy) else $error("txrdy pin wrong");
  property p_txrdy_op;
    (!txrdy_func_sel && $stable(out_port_data[OP_TXRDY_BIT]))[*2]
      |-> transmit_ready_chan_a_n == out_port_data[OP_TXRDY_BIT];
  endproperty
  a_txrdy_op: assert property (p_txrdy_op) else $error("txrdy discrete wrong");
  property p_rxrdy;
    (!rxrdy_mode[1] && $stable(rxrdy_mode) && $stable(int_status[ISR_RX_BIT]))[*3]
      |-> receive_ready_chan_a_n == !int_status[ISR_RX_BIT];
  endproperty
  a_rxrdy: assert property (p_rxrdy) else $error("rxrdy pin wrong");
  property p_rxrdy_op;
    (rxrdy_mode[1] && $stable(out_port_data[OP_RXRDY_BIT]))[*2]
      |-> receive_ready_chan_a_n == out_port_data[OP_RXRDY_BIT];
  endproperty
  a_rxrdy_op: assert property (p_rxrdy_op) else $error("rxrdy discrete wrong");
  property p_mark_a;
    (loopback[0] || !tx_enable[0])[*4] |-> serial_out_chan_a;
  endproperty
  a_mark_a: assert property (p_mark_a) else $error("line a not at mark");
  property p_mark_b;
    (loopback[1] || !tx_enable[1])[*4] |-> serial_out_chan_b;
  endproperty
  a_mark_b: assert property (p_mark_b) else $error("line b not at mark");
  property p_shift_a;
    $changed(serial_out_chan_a) && ext_clk_sel[0] && $past(ext_clk_sel[0], 8) && tx_enable[0]
      && $past(tx_enable[0], 8) && !loopback[0] |-> fall_age_ff inside {[4'h1:4'h5]};
  endproperty
  a_shift_a: assert property (p_shift_a) else $error("line a moved off falling edge");
  c_full: cover property (status_chan_a[SR_FFULL]);
  c_rts: cover property (rts_func_sel[0] && !request_to_send_chan_a_n);
  c_loop: cover property (loopback[1] && tx_enable[1]);
endmodule : ducp_checker
bind ducp_top ducp_checker u_ducp_checker (
  .core_clk(core_clk), .reset_n(reset_n), .serial_out_chan_a(serial_out_chan_a),
  .serial_out_chan_b(serial_out_chan_b), .serial_clk_ext(serial_clk_ext),
  .request_to_send_chan_a_n(request_to_send_chan_a_n),
  .request_to_send_chan_b_n(request_to_send_chan_b_n),
  .transmit_ready_chan_a_n(transmit_ready_chan_a_n),
  .receive_ready_chan_a_n(receive_ready_chan_a_n), .tx_enable(tx_enable),
  .loopback(loopback), .ext_clk_sel(ext_clk_sel), .rts_func_sel(rts_func_sel),
  .rts_request(rts_request), .txrdy_func_sel(txrdy_func_sel), .rxrdy_mode(rxrdy_mode),
  .out_port_data(out_port_data), .status_chan_a(status_chan_a), .int_status(int_status));
`default_nettype wire

//--- sim/ducp_line_model.sv
// Remote line partner: bit clock, receive line driver and transmit line capture
`default_nettype none
module ducp_line_model (
  // Line side
  output logic      bit_clk,
  output logic      line_out,
  input  wire logic line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bit_clk  = 1'b0;
    line_out = 1'b1;
  end
  // Clock runs only inside a frame; the line idles at mark between frames
  task automatic run(input logic [7:0] data, output logic [7:0] cap, output logic ok);
    logic [11:0] frame;
    int          n;
    frame = {3'h7, data, 1'b0};
    n = -1;
    ok = 1'b0;
    cap = 8'h00;
    for (int k = 0; k < 12; k++) begin
      line_out = frame[k]; // Set while clock low so it is steady at the rise
      #31 bit_clk = 1'b1;
      if (n < 0 && !line_in) begin
        n = 0;
      end else if (n >= 0 && n < 8) begin
        cap[n] = line_in; // First data bit is the LSB
        n++;
      end else if (n == 8) begin
        ok = line_in;
        n++;
      end
      #31 bit_clk = 1'b0;
    end
  endtask : run
endmodule : ducp_line_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the dual serial pin block
`default_nettype none
module tb_top
  import ducp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk = 1'b0, reset_n = 1'b0, serial_osc_in = 1'b0;
  logic                cts_a_n = 1'b1, cts_b_n = 1'b1, txrdy_func_sel = 1'b0;
  logic [1:0]          tx_enable = 2'h0, loopback = 2'h0, cts_enable = 2'h0;
  logic [1:0]          ext_clk_sel = 2'h3, rts_func_sel = 2'h0, rts_request = 2'h0;
  logic [1:0]          tx_write = 2'h0, rx_read = 2'h0, overrun_clr = 2'h0;
  logic [BAUD_W-1:0]   baud_div = 16'h0002;
  logic [7:0]          out_port_data = 8'h00, tx_data = 8'h00;
  ducp_rdy_mode_t      rxrdy_mode = RDY_DISCRETE;
  wire logic           clk_ext, in_a;
  logic                out_a, out_b, rts_a_n, rts_b_n, txrdy_n, rxrdy_n;
  logic [7:0]          rx_a, rx_b, int_status;
  logic [SR_WIDTH-1:0] st_a, st_b;
  logic [7:0]          rxv [3] = '{8'h3c, 8'hc3, 8'h81};
  int                  failures = 0, total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  // Oscillator at an eighth of the core rate, inside the sampling limit
  always begin
    repeat (4) @(posedge core_clk);
    serial_osc_in <= ~serial_osc_in;
  end
  // Channel B listens to channel A's line so both receivers see traffic
  ducp_top u_ducp_top (
    .core_clk(core_clk), .reset_n(reset_n), .serial_in_chan_a(in_a), .serial_in_chan_b(out_a),
    .serial_out_chan_a(out_a), .serial_out_chan_b(out_b), .clear_to_send_chan_a_n(cts_a_n),
    .clear_to_send_chan_b_n(cts_b_n), .serial_osc_in(serial_osc_in), .serial_clk_ext(clk_ext),
    .request_to_send_chan_a_n(rts_a_n), .request_to_send_chan_b_n(rts_b_n),
    .transmit_ready_chan_a_n(txrdy_n), .receive_ready_chan_a_n(rxrdy_n),
    .tx_enable(tx_enable), .loopback(loopback), .cts_enable(cts_enable),
    .ext_clk_sel(ext_clk_sel), .baud_div(baud_div), .rts_func_sel(rts_func_sel),
    .rts_request(rts_request), .txrdy_func_sel(txrdy_func_sel), .rxrdy_mode(rxrdy_mode),
    .out_port_data(out_port_data), .tx_write(tx_write), .tx_data_chan_a(tx_data),
    .tx_data_chan_b(tx_data), .rx_read(rx_read), .overrun_clr(overrun_clr),
    .rx_data_chan_a(rx_a), .rx_data_chan_b(rx_b), .status_chan_a(st_a),
    .status_chan_b(st_b), .int_status(int_status));
  ducp_line_model u_ducp_line_model (.bit_clk(clk_ext), .line_out(in_a), .line_in(out_a));
  // ***********************************************
  // Access tasks
  // ***********************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte
  task automatic wr_tx(input int ch, input logic [7:0] d);
    @(posedge core_clk);
    tx_data <= d;
    tx_write[ch] <= 1'b1;
    @(posedge core_clk);
    tx_write <= 2'h0;
    cyc(2);
  endtask : wr_tx
  task automatic rd_rx(input int ch);
    @(posedge core_clk);
    rx_read[ch] <= 1'b1;
    overrun_clr[ch] <= 1'b1;
    @(posedge core_clk);
    rx_read <= 2'h0;
    overrun_clr <= 2'h0;
    cyc(3);
  endtask : rd_rx
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  // ***********************************************
  // Tests
  // ***********************************************
  initial begin
    logic [7:0] cap;
    logic       ok;
    cyc(3);
    cmp_bit("line a in reset", 1'b1, out_a);
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      out_port_data <= i ? 8'hac : 8'h53;
      rxrdy_mode <= i ? ducp_rdy_mode_t'(2'h3) : RDY_DISCRETE;
      cyc(3);
      cmp_bit("rts a discrete", out_port_data[0], rts_a_n);
      cmp_bit("rts b discrete", out_port_data[1], rts_b_n);
      cmp_bit("txrdy discrete", out_port_data[6], txrdy_n);
      cmp_bit("rxrdy discrete", out_port_data[4], rxrdy_n);
    end
    @(posedge core_clk);
    rts_func_sel <= 2'h3;
    rts_request <= 2'h1;
    tx_enable <= 2'h3;
    cts_enable <= 2'h3;
    txrdy_func_sel <= 1'b1;
    rxrdy_mode <= RDY_FFULL;
    cyc(4);
    cmp_bit("rts a asserted", 1'b0, rts_a_n);
    cmp_bit("rts b negated", 1'b1, rts_b_n);
    cmp_bit("txrdy empty", 1'b0, txrdy_n);
    wr_tx(0, 8'ha5);
    cyc(2);
    cmp_bit("txrdy held", 1'b1, txrdy_n);
    // Frame 0 has clear-to-send negated so the character waits; frame 3 overruns
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      cts_a_n <= (i == 0);
      cyc(4);
      u_ducp_line_model.run(rxv[i % 3], cap, ok);
      cyc(6);
      cmp_bit("frame sent", i == 1, ok);
      if (i == 1) cmp_byte("line a data", 8'ha5, cap);
    end
    cmp_bit("b char avail", 1'b1, st_b[SR_RXRDY]);
    cmp_byte("rx b", 8'ha5, rx_b);
    rd_rx(1);
    for (int i = 0; i < 3; i++) begin
      cmp_bit("ffull pin", i != 0, rxrdy_n);
      cmp_byte("rx a", rxv[i], rx_a);
      cmp_bit("overrun flag", i == 0, st_a[SR_OVRUN]);
      cmp_bit("isr full", i == 0, int_status[ISR_RX_BIT]);
      rd_rx(0);
    end
    @(posedge core_clk);
    rxrdy_mode <= RDY_RXRDY;
    cyc(4);
    cmp_bit("rxrdy drained", 1'b1, rxrdy_n);
    @(posedge core_clk);
    loopback <= 2'h2;
    cts_b_n <= 1'b0;
    wr_tx(1, 8'h96);
    u_ducp_line_model.run(8'hff, cap, ok);
    cyc(6);
    cmp_bit("line b mark", 1'b1, out_b);
    cmp_byte("rx b looped", 8'h96, rx_b);
    cmp_bit("rxrdy one char", 1'b0, rxrdy_n);
    @(posedge core_clk);
    ext_clk_sel <= 2'h2;
    wr_tx(0, 8'h00);
    for (int n = 0; n < 400 && out_a !== 1'b0; n++) cyc(1);
    cmp_bit("baud start bit", 1'b0, out_a);
    cyc(400);
    summarize();
  end
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
